//--- inc/fsq_pkg.sv
// package: register map, field layout, codes and state types of the sequencer block
package fsq_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int CNT_W = 16;
	localparam int CMD_W = 3;
	localparam int ERR_W = 6;

	// byte addresses of the register words
	localparam logic [ADDR_W-1:0] OFS_ADDR_LOW = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_ADDR_HIGH = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_END_LOW = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_END_HIGH = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_WDATA_LOW = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_WDATA_HIGH = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_AREA_SEL = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_EXTRA_CTRL = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS_HIGH = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_ERR_STATUS = 6'h28;
	localparam logic [ADDR_W-1:0] OFS_REG_INIT = 6'h2c;
	localparam logic [ADDR_W-1:0] OFS_SETTING = 6'h30;
	localparam logic [ADDR_W-1:0] OFS_BOOT_STATUS = 6'h34;

	// field positions
	localparam int BIT_START = 7;
	localparam int BIT_STOP = 6;
	localparam int BIT_EXTRA_END = 7;
	localparam int BIT_MAIN_END = 6;
	localparam int BIT_SWAP = 7;
	localparam int BIT_CLUSTER = 6;
	localparam int BIT_BOOT_CL1 = 0;
	localparam int BIT_MAIN_BUSY = 1;
	localparam int BIT_EXTRA_BUSY = 2;
	localparam int ERR_EXTRA = 5;
	localparam int ERR_MAIN = 4;
	localparam int ERR_BLANK = 3;
	localparam int ERR_WRITE = 1;
	localparam int ERR_ERASE = 0;

	localparam logic [ERR_W-1:0] ERR_VALID = 6'h3b;
	localparam logic [ERR_W-1:0] ERR_MAIN_SET = 6'h1b;

	// command codes in the low bits of main_seq_ctrl
	localparam logic [CMD_W-1:0] CMD_WRITE = 3'h1;
	localparam logic [CMD_W-1:0] CMD_BLANK = 3'h3;
	localparam logic [CMD_W-1:0] CMD_ERASE = 3'h4;

	localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
	localparam logic [REG_W-1:0] INIT_ARM = 8'h01;
	localparam logic [REG_W-1:0] INIT_FIRE = 8'h00;
	localparam logic [REG_W-1:0] OPC_ILLEGAL = 8'hff;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_RUN = 2'b01,
		SQ_DONE = 2'b10
	} fsq_seq_t;

	typedef struct packed {
		logic [REG_W-1:0] addrLow, addrHigh, endLow, endHigh;
		logic [REG_W-1:0] wdLow, wdHigh, areaSel;
		logic [REG_W-1:0] mainCtrl, extraCtrl, setting;
		logic [ERR_W-1:0] errStat;
		fsq_seq_t mainSt;
		fsq_seq_t extraSt;
		logic [CNT_W-1:0] mainCnt;
		logic [CNT_W-1:0] extraCnt;
		logic initArmed;
		logic bootCluster1;
		logic ack;
		logic resetReq;
		logic [DATA_W-1:0] rdata;
	} fsq_state_t;

	typedef struct packed {
		logic [2:0] chain;
		logic level;
	} fsq_sync_t;

	localparam fsq_state_t ST_RESET = '0;
	localparam fsq_sync_t SYNC_RESET = '0;

endpackage : fsq_pkg

//--- src/fsq_pin_sync.sv
// three-stage synchroniser for a pin level, with agreement filter
`timescale 1ns/1ps
module fsq_pin_sync import fsq_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic pinIn,
	output logic level
);
	fsq_sync_t s_r;
	fsq_sync_t s_nxt;

	// stage 0 feeds only stage 1; the level moves when stages 1 and 2 agree
	always_comb begin
		s_nxt = s_r;
		s_nxt.chain = {s_r.chain[1:0], pinIn};
		if (s_r.chain[1] == s_r.chain[2]) begin
			s_nxt.level = s_r.chain[2];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= SYNC_RESET;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.level;
endmodule : fsq_pin_sync

//--- src/fsq_seq_ctrl.sv
// flash sequencer status, clearing, forced stop and boot swap with avalon slave
//
// How it works
// - extra end flag drops only after extra sequencer done and its control cleared
// - error register: bit5 extra, bit4 main, bit3 blank, bit1 write, bit0 erase
// - init arm then fire clears address, data, area and control registers
// - init pulse leaves error register unchanged
// - stop bit during blank check or erase halts main sequencer
// - illegal opcode 0xff raises an internal cpu reset request
// - no reset from illegal opcode while debugger active
// - setting write with bit7 remaps boot, bit6 picks cluster
// - unchosen cluster sits directly after the boot area
// - any cpu reset reloads boot cluster from security boot flag
// - extra end flag set when extra sequencer operation finishes
// - main end flag set at completion, cleared after control cleared
// - main control: bit7 start, bits 2..0 command, 4 erase
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module fsq_seq_ctrl import fsq_pkg::*; #(
	parameter int MAIN_CYCLES = 16,
	parameter int EXTRA_CYCLES = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic mainFailIn,
	input wire logic extraFailIn,
	input wire logic opcodeValid,
	input wire logic [REG_W-1:0] opcode,
	input wire logic debugActivePin,
	input wire logic securityBootFlag,
	output logic mainSeqBusy,
	output logic extraSeqBusy,
	output logic bootCluster1,
	output logic upperCluster1,
	output logic cpuResetReq
);
	localparam logic [CNT_W-1:0] MAIN_LOAD = CNT_W'(MAIN_CYCLES);
	localparam logic [CNT_W-1:0] EXTRA_LOAD = CNT_W'(EXTRA_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	fsq_state_t s_r;
	fsq_state_t s_nxt;
	logic dbgActive;
	logic busReq;
	logic wrTake;
	logic rdTake;
	logic [REG_W-1:0] wb;

	fsq_pin_sync u_dbg_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.pinIn(debugActivePin),
		.level(dbgActive)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// pure decode of state, so reading never disturbs anything
	function automatic logic [DATA_W-1:0] regRead(input fsq_state_t st,
		input logic [ADDR_W-1:0] a);
		logic [REG_W-1:0] v;
		v = REG_ZERO;
		case (a)
			OFS_ADDR_LOW: v = st.addrLow;
			OFS_ADDR_HIGH: v = st.addrHigh;
			OFS_END_LOW: v = st.endLow;
			OFS_END_HIGH: v = st.endHigh;
			OFS_WDATA_LOW: v = st.wdLow;
			OFS_WDATA_HIGH: v = st.wdHigh;
			OFS_AREA_SEL: v = st.areaSel;
			OFS_MAIN_CTRL: v = st.mainCtrl;
			OFS_EXTRA_CTRL: v = st.extraCtrl;
			OFS_STATUS_HIGH: begin
				v[BIT_EXTRA_END] = (st.extraSt == SQ_DONE);
				v[BIT_MAIN_END] = (st.mainSt == SQ_DONE);
			end
			OFS_ERR_STATUS: v = REG_W'(st.errStat & ERR_VALID);
			OFS_SETTING: v = st.setting;
			OFS_BOOT_STATUS: begin
				v[BIT_BOOT_CL1] = st.bootCluster1;
				v[BIT_MAIN_BUSY] = (st.mainSt == SQ_RUN);
				v[BIT_EXTRA_BUSY] = (st.extraSt == SQ_RUN);
			end
			default: v = REG_ZERO;
		endcase
		return {{(DATA_W-REG_W){1'b0}}, v};
	endfunction : regRead

	// error bits raised by a failing main command
	function automatic logic [ERR_W-1:0] cmdErr(input logic [CMD_W-1:0] c);
		logic [ERR_W-1:0] e;
		e = '0;
		e[ERR_MAIN] = 1'b1;
		case (c)
			CMD_ERASE: e[ERR_ERASE] = 1'b1;
			CMD_WRITE: e[ERR_WRITE] = 1'b1;
			CMD_BLANK: e[ERR_BLANK] = 1'b1;
			default: e[ERR_MAIN] = 1'b1;
		endcase
		return e;
	endfunction : cmdErr

	function automatic logic stoppable(input logic [CMD_W-1:0] c);
		return (c == CMD_ERASE) || (c == CMD_BLANK);
	endfunction : stoppable

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then accept

	assign busReq = read || write;
	assign waitrequest = busReq && !(s_r.ack && ce);
	assign wrTake = write && s_r.ack && ce;
	assign rdTake = read && s_r.ack && ce;
	assign wb = writedata[REG_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = busReq && !s_r.ack;
		s_nxt.resetReq = 1'b0;
		if (busReq && !s_r.ack && read) begin
			s_nxt.rdata = regRead(s_r, address);
		end

		// main sequencer
		unique case (s_r.mainSt)
			SQ_IDLE: s_nxt.mainCnt = '0;
			SQ_RUN: begin
				if (s_r.mainCnt <= CNT_ONE) begin
					s_nxt.mainSt = SQ_DONE;
					s_nxt.mainCnt = '0;
					if (mainFailIn) begin
						s_nxt.errStat = s_r.errStat |
							cmdErr(s_r.mainCtrl[CMD_W-1:0]);
					end
				end else begin
					s_nxt.mainCnt = s_r.mainCnt - CNT_ONE;
				end
			end
			SQ_DONE: begin
				if (s_r.mainCtrl == REG_ZERO) begin
					s_nxt.mainSt = SQ_IDLE;
				end
			end
			default: s_nxt.mainSt = SQ_IDLE;
		endcase

		// extra-area sequencer
		unique case (s_r.extraSt)
			SQ_IDLE: s_nxt.extraCnt = '0;
			SQ_RUN: begin
				if (s_r.extraCnt <= CNT_ONE) begin
					s_nxt.extraSt = SQ_DONE;
					s_nxt.extraCnt = '0;
					if (extraFailIn) begin
						s_nxt.errStat[ERR_EXTRA] = 1'b1;
					end
				end else begin
					s_nxt.extraCnt = s_r.extraCnt - CNT_ONE;
				end
			end
			SQ_DONE: begin
				if (s_r.extraCtrl == REG_ZERO) begin
					s_nxt.extraSt = SQ_IDLE;
				end
			end
			default: s_nxt.extraSt = SQ_IDLE;
		endcase

		// register writes, low byte lane only
		if (wrTake && byteenable[0]) begin
			case (address)
				OFS_ADDR_LOW: s_nxt.addrLow = wb;
				OFS_ADDR_HIGH: s_nxt.addrHigh = wb;
				OFS_END_LOW: s_nxt.endLow = wb;
				OFS_END_HIGH: s_nxt.endHigh = wb;
				OFS_WDATA_LOW: s_nxt.wdLow = wb;
				OFS_WDATA_HIGH: s_nxt.wdHigh = wb;
				OFS_AREA_SEL: s_nxt.areaSel = wb;
				OFS_MAIN_CTRL: begin
					s_nxt.mainCtrl = wb;
					if (wb[BIT_START] && s_r.mainSt == SQ_IDLE) begin
						s_nxt.mainSt = SQ_RUN;
						s_nxt.mainCnt = MAIN_LOAD;
						// keeps an extra error raised in this same cycle
						s_nxt.errStat = s_nxt.errStat & ~ERR_MAIN_SET;
					end
					if (wb[BIT_STOP] && s_r.mainSt == SQ_RUN &&
						stoppable(s_r.mainCtrl[CMD_W-1:0])) begin
						s_nxt.mainSt = SQ_DONE;
						s_nxt.mainCnt = '0;
					end
				end
				OFS_EXTRA_CTRL: begin
					s_nxt.extraCtrl = wb;
					if (wb[BIT_START] && s_r.extraSt == SQ_IDLE) begin
						s_nxt.extraSt = SQ_RUN;
						s_nxt.extraCnt = EXTRA_LOAD;
						s_nxt.errStat[ERR_EXTRA] = 1'b0;
					end
				end
				OFS_REG_INIT: begin
					s_nxt.initArmed = (wb == INIT_ARM);
					if (wb == INIT_FIRE && s_r.initArmed) begin
						// error register deliberately untouched
						s_nxt.addrLow = REG_ZERO;
						s_nxt.addrHigh = REG_ZERO;
						s_nxt.endLow = REG_ZERO;
						s_nxt.endHigh = REG_ZERO;
						s_nxt.wdLow = REG_ZERO;
						s_nxt.wdHigh = REG_ZERO;
						s_nxt.areaSel = REG_ZERO;
						s_nxt.mainCtrl = REG_ZERO;
						s_nxt.extraCtrl = REG_ZERO;
					end
				end
				OFS_SETTING: begin
					s_nxt.setting = wb;
					if (wb[BIT_SWAP]) begin
						s_nxt.bootCluster1 = wb[BIT_CLUSTER];
					end
				end
				default: s_nxt.setting = s_r.setting;
			endcase
		end

		if (opcodeValid && opcode == OPC_ILLEGAL && !dbgActive) begin
			s_nxt.resetReq = 1'b1;
		end
		if (s_r.resetReq) begin
			s_nxt.bootCluster1 = !securityBootFlag;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= ST_RESET;
			// flag set means cluster 0 boots
			s_r.bootCluster1 <= !securityBootFlag;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign readdata = s_r.rdata;
	assign mainSeqBusy = (s_r.mainSt == SQ_RUN);
	assign extraSeqBusy = (s_r.extraSt == SQ_RUN);
	assign bootCluster1 = s_r.bootCluster1;
	assign upperCluster1 = !s_r.bootCluster1;
	assign cpuResetReq = s_r.resetReq;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_extra_end_drop: assert property (
		$fell(s_r.extraSt == SQ_DONE) |->
			$past(s_r.extraCtrl) == REG_ZERO && !extraSeqBusy)
		else $error("extra end flag dropped before control cleared");

	a_err_read_layout: assert property (
		rdTake && address == OFS_ERR_STATUS |->
			readdata[7:6] == 2'b00 && readdata[2] == 1'b0)
		else $error("error register shows reserved bits set");

	a_init_clears: assert property (
		wrTake && byteenable[0] && address == OFS_REG_INIT &&
		wb == INIT_FIRE && s_r.initArmed |=>
			s_r.addrLow == REG_ZERO && s_r.endHigh == REG_ZERO &&
			s_r.wdLow == REG_ZERO && s_r.areaSel == REG_ZERO &&
			s_r.mainCtrl == REG_ZERO && s_r.extraCtrl == REG_ZERO)
		else $error("init pulse left a register set");

	a_init_keeps_err: assert property (
		wrTake && address == OFS_REG_INIT && s_r.initArmed &&
		!mainSeqBusy && !extraSeqBusy |=> $stable(s_r.errStat))
		else $error("init pulse changed error register");

	a_stop_halts: assert property (
		wrTake && byteenable[0] && address == OFS_MAIN_CTRL &&
		wb[BIT_STOP] && mainSeqBusy &&
		stoppable(s_r.mainCtrl[CMD_W-1:0]) |=>
			!mainSeqBusy && s_r.mainSt == SQ_DONE)
		else $error("forced stop did not halt main sequencer");

	a_opcode_reset: assert property (
		ce && opcodeValid && opcode == OPC_ILLEGAL && !dbgActive |=>
			cpuResetReq ##1 bootCluster1 == !$past(securityBootFlag))
		else $error("illegal opcode gave no reset request");

	a_debug_no_reset: assert property (
		ce && dbgActive |=> !cpuResetReq)
		else $error("reset requested while debugger active");

	a_boot_remap: assert property (
		wrTake && byteenable[0] && address == OFS_SETTING && wb[BIT_SWAP]
		&& !s_r.resetReq |=> bootCluster1 == $past(writedata[BIT_CLUSTER])
			&& upperCluster1 != bootCluster1)
		else $error("boot remap not applied");

	a_boot_on_reset: assert property (
		@(posedge clk) disable iff (1'b0)
		reset |=> bootCluster1 == !$past(securityBootFlag))
		else $error("boot cluster not reloaded at reset");

	a_main_end_clear: assert property (
		ce && s_r.mainSt == SQ_DONE && s_r.mainCtrl == REG_ZERO |=>
			s_r.mainSt == SQ_IDLE)
		else $error("main end flag stuck after control cleared");

	a_read_no_effect: assert property (
		rdTake && !mainSeqBusy && !extraSeqBusy && !write |=>
			$stable(s_r.errStat) && $stable(s_r.mainSt) &&
			$stable(s_r.extraSt))
		else $error("read disturbed sequencer state");

	a_run_length: assert property (
		$rose(extraSeqBusy) ##1 ce [*2] |-> extraSeqBusy ||
			s_r.extraSt == SQ_DONE)
		else $error("extra sequencer left run state wrongly");

	c_main_done: cover property ($rose(s_r.mainSt == SQ_DONE));
	c_extra_done: cover property ($rose(s_r.extraSt == SQ_DONE));
	c_forced_stop: cover property (wrTake && address == OFS_MAIN_CTRL &&
		wb[BIT_STOP] && mainSeqBusy);
	c_boot_swap: cover property ($changed(bootCluster1));
endmodule : fsq_seq_ctrl

//--- tb/fsq_testbench.sv
// self-checking bench for the flash sequencer status and control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
	miscompares++; end end

module testbench import fsq_pkg::*;;
	logic clk, reset, ce, read, write;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata, readdata, q;
	logic [3:0] byteenable;
	logic waitrequest, mainFailIn, extraFailIn, opcodeValid;
	logic [REG_W-1:0] opcode;
	logic debugActivePin, securityBootFlag;
	logic mainSeqBusy, extraSeqBusy, bootCluster1, upperCluster1, cpuResetReq;
	int miscompares = 0;
	int testsRun = 0;
	int hits;
	logic [CMD_W-1:0] cmds [3] = '{CMD_ERASE, CMD_BLANK, CMD_WRITE};
	logic [ERR_W-1:0] errs [3] = '{6'h11, 6'h18, 6'h12};

	fsq_seq_ctrl #(.MAIN_CYCLES(12), .EXTRA_CYCLES(4)) dut_u (
		.clk(clk), .reset(reset), .ce(ce), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.mainFailIn(mainFailIn), .extraFailIn(extraFailIn),
		.opcodeValid(opcodeValid), .opcode(opcode),
		.debugActivePin(debugActivePin), .securityBootFlag(securityBootFlag),
		.mainSeqBusy(mainSeqBusy), .extraSeqBusy(extraSeqBusy),
		.bootCluster1(bootCluster1), .upperCluster1(upperCluster1),
		.cpuResetReq(cpuResetReq)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////
	// called just after a rising edge; request held until waitrequest low
	task automatic access(input logic [ADDR_W-1:0] a, input logic wr,
		input logic [REG_W-1:0] d, output logic [DATA_W-1:0] r);
		int n;
		logic taken;
		n = 0;
		taken = 1'b0;
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h000000, d};
		while (!taken) begin
			@(negedge clk);
			taken = !waitrequest;
			r = readdata;
			@(posedge clk);
			n++;
			if (n > 20) begin
				miscompares++;
				finish_test();
			end
		end
	endtask : access

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		logic [DATA_W-1:0] r;
		access(a, 1'b1, d, r);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] r);
		access(a, 1'b0, 8'h00, r);
	endtask : rd

	task automatic idle();
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : idle

	// poll a status bit until it reaches the wanted value, bounded
	task automatic poll(input int b, input logic v);
		logic [DATA_W-1:0] r;
		int n;
		n = 0;
		rd(OFS_STATUS_HIGH, r);
		while (r[b] !== v && n < 40) begin
			rd(OFS_STATUS_HIGH, r);
			n++;
		end
		`CHK("status flag", v, r[b])
	endtask : poll

	task automatic fire(input logic [REG_W-1:0] op, output int h);
		h = 0;
		opcode <= op;
		opcodeValid <= 1'b1;
		@(posedge clk);
		opcodeValid <= 1'b0;
		repeat (4) begin
			@(negedge clk);
			if (cpuResetReq !== 1'b0) h++;
			@(posedge clk);
		end
	endtask : fire

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	////////////////////////////////////////////////////////////////////////
	initial begin
		ce = 1'b1;
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		byteenable = 4'hf;
		mainFailIn = 1'b0;
		extraFailIn = 1'b0;
		opcodeValid = 1'b0;
		opcode = 8'h00;
		debugActivePin = 1'b0;
		securityBootFlag = 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("boot after reset", 1'b0, bootCluster1)
		`CHK("upper after reset", 1'b1, upperCluster1)
		rd(OFS_ERR_STATUS, q);
		`CHK("error after reset", 32'h0, q)
		done("reset");

		wr(OFS_MAIN_CTRL, 8'h84);
		rd(OFS_BOOT_STATUS, q);
		`CHK("main busy", 1'b1, q[BIT_MAIN_BUSY])
		poll(BIT_MAIN_END, 1'b1);
		`CHK("main busy pin", 1'b0, mainSeqBusy)
		rd(OFS_ERR_STATUS, q);
		`CHK("clean erase", 32'h0, q)
		rd(OFS_STATUS_HIGH, q);
		`CHK("end kept by reads", 1'b1, q[BIT_MAIN_END])
		wr(OFS_MAIN_CTRL, REG_ZERO);
		poll(BIT_MAIN_END, 1'b0);
		done("main erase");

		mainFailIn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(OFS_MAIN_CTRL, {5'h10, cmds[i]});
			poll(BIT_MAIN_END, 1'b1);
			rd(OFS_ERR_STATUS, q);
			`CHK("main error", {26'h0, errs[i]}, q)
			wr(OFS_MAIN_CTRL, REG_ZERO);
			poll(BIT_MAIN_END, 1'b0);
		end
		mainFailIn <= 1'b0;
		done("main errors");

		extraFailIn <= 1'b1;
		wr(OFS_EXTRA_CTRL, 8'h80);
		idle();
		`CHK("extra busy pin", 1'b1, extraSeqBusy)
		poll(BIT_EXTRA_END, 1'b1);
		rd(OFS_ERR_STATUS, q);
		`CHK("extra error", 32'h32, q)
		rd(OFS_STATUS_HIGH, q);
		`CHK("extra end held", 1'b1, q[BIT_EXTRA_END])
		wr(OFS_EXTRA_CTRL, REG_ZERO);
		poll(BIT_EXTRA_END, 1'b0);
		extraFailIn <= 1'b0;
		done("extra");

		for (int i = 0; i < 7; i++) wr(6'(i * 4), 8'(8'h5a + i));
		byteenable <= 4'he;
		wr(OFS_AREA_SEL, 8'hff);
		byteenable <= 4'hf;
		rd(OFS_AREA_SEL, q);
		`CHK("lane off write", 32'h60, q)
		wr(OFS_REG_INIT, INIT_ARM);
		wr(OFS_REG_INIT, INIT_FIRE);
		for (int i = 0; i < 9; i++) begin
			rd(6'(i * 4), q);
			`CHK("cleared reg", 32'h0, q)
		end
		rd(OFS_ERR_STATUS, q);
		`CHK("errors kept", 32'h32, q)
		`CHK("error code", 6'h32, q[ERR_W-1:0])
		rd(6'h3c, q);
		`CHK("unmapped", 32'h0, q)
		done("init");

		wr(OFS_MAIN_CTRL, 8'h84);
		wr(OFS_MAIN_CTRL, 8'hc4);
		rd(OFS_STATUS_HIGH, q);
		`CHK("stopped end", 1'b1, q[BIT_MAIN_END])
		`CHK("stopped busy", 1'b0, mainSeqBusy)
		wr(OFS_MAIN_CTRL, REG_ZERO);
		poll(BIT_MAIN_END, 1'b0);
		wr(OFS_MAIN_CTRL, 8'h84);
		idle();
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("frozen run", 1'b1, mainSeqBusy)
		ce <= 1'b1;
		poll(BIT_MAIN_END, 1'b1);
		rd(OFS_ERR_STATUS, q);
		`CHK("re-erase errors", 32'h20, q)
		wr(OFS_MAIN_CTRL, REG_ZERO);
		poll(BIT_MAIN_END, 1'b0);
		done("stop");

		wr(OFS_SETTING, 8'hc5);
		rd(OFS_SETTING, q);
		`CHK("setting", 32'hc5, q)
		`CHK("boot cluster 1", 1'b1, bootCluster1)
		`CHK("upper cluster 0", 1'b0, upperCluster1)
		rd(OFS_BOOT_STATUS, q);
		`CHK("boot status", 1'b1, q[BIT_BOOT_CL1])
		wr(OFS_SETTING, 8'h85);
		rd(OFS_BOOT_STATUS, q);
		`CHK("boot cluster 0", 1'b0, bootCluster1)
		`CHK("upper cluster 1", 1'b1, upperCluster1)
		done("boot");

		wr(OFS_SETTING, 8'hc0);
		idle();
		fire(8'hfe, hits);
		`CHK("legal opcode", 0, hits)
		fire(OPC_ILLEGAL, hits);
		`CHK("illegal opcode", 1, hits)
		`CHK("boot after cpu reset", 1'b0, bootCluster1)
		debugActivePin <= 1'b1;
		repeat (8) @(posedge clk);
		fire(OPC_ILLEGAL, hits);
		`CHK("debugger present", 0, hits)
		debugActivePin <= 1'b0;
		done("opcode");

		wr(OFS_SETTING, 8'hc0);
		idle();
		wr(OFS_SETTING, 8'h80);
		idle();
		securityBootFlag <= 1'b0;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("boot from flag", 1'b1, bootCluster1)
		done("reset reload");
		finish_test();
	end
endmodule : testbench
